// >>> core/upd_pkg.sv
// shared constants and carriers of the phy access and dma control block
package upd_pkg;

  // register byte offsets
  localparam logic [11:0] UPD_ACC_OFS = 12'h120;
  localparam logic [11:0] UPD_CTRL_OFS = 12'h124;
  localparam logic [11:0] UPD_STAT_OFS = 12'h128;
  localparam logic [11:0] UPD_DSR_OFS = 12'h200;
  localparam logic [11:0] UPD_DCR_OFS = 12'h204;

  // field positions
  localparam int UPD_BUSY_BIT = 31;
  localparam int UPD_BYTE_LSB = 8;
  localparam int UPD_WR_BIT = 6;
  localparam int UPD_MRDY_BIT = 0;
  localparam int UPD_DONE_BIT = 0;
  localparam int UPD_DIR_BIT = 31;
  localparam int UPD_SEL_BIT = 30;

  // readable bit masks, dma reset key and reset values
  localparam logic [31:0] UPD_ACC_MASK = 32'h8000_ff7f;
  localparam logic [31:0] UPD_DCR_MASK = 32'hc000_fefe;
  localparam logic [31:0] UPD_DMA_KEY = 32'h0000_000a;
  localparam logic [15:0] UPD_DCR_RST = 16'h0000;
  localparam logic [14:0] UPD_ACC_RST = 15'h0000;

  // ulpi transmit command prefixes
  localparam logic [1:0] UPD_TXCMD_WR = 2'h2;
  localparam logic [1:0] UPD_TXCMD_RD = 2'h3;

  // sampled ulpi pins
  typedef struct packed {
    logic clk;
    logic dir;
    logic nxt;
    logic [7:0] data;
  } upd_ulpi_in_t;

  // driven ulpi pins, doe_n low while driving data
  typedef struct packed {
    logic stp;
    logic [7:0] dout;
    logic doe_n;
  } upd_ulpi_out_t;

  // dma control fields
  typedef struct packed {
    logic dir;
    logic sel;
    logic [6:0] rdy1;
    logic [6:0] rdy0;
  } upd_dma_ctl_t;

  // transceiver access fields
  typedef struct packed {
    logic [7:0] xcvr_rw_byte;
    logic xfer_dir_wr;
    logic [5:0] xcvr_reg_index;
  } upd_acc_t;

  // ulpi register access sequencer states
  typedef enum logic [2:0] {
    UPD_ST_IDLE,
    UPD_ST_CMD,
    UPD_ST_WDAT,
    UPD_ST_STP,
    UPD_ST_RTA,
    UPD_ST_RDAT
  } upd_ust_t;

endpackage : upd_pkg

// >>> core/upd_sync3.sv
// three stage synchroniser, a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module upd_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // raw and filtered levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  // shift chain, first stage read only by the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // take a bit only where the later stages agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= '0;
    end else begin
      q_q <= (s3_q & ~(s2_q ^ s3_q)) | (q_q & (s2_q ^ s3_q));
    end
  end

  assign q = q_q;

endmodule : upd_sync3
`default_nettype wire

// >>> core/upd_dma_rst.sv
// keyed software reset pulse for the dma modules
`timescale 1ns/1ps
`default_nettype none
module upd_dma_rst #(
  parameter bit OPT = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // committed write to the reset register
  input wire logic key_wr,
  input wire logic [31:0] wdata,
  // one cycle reset pulse
  output logic rst_pulse
);
  import upd_pkg::*;

  logic rst_q;

  generate
    if (OPT) begin : g_dma
      // only the exact key fires the reset
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rst_q <= 1'b0;
        end else begin
          rst_q <= key_wr && (wdata == UPD_DMA_KEY); // RQ11
        end
      end
    end else begin : g_nodma
      // no dma modules, the register does nothing
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rst_q <= 1'b0;
        end else begin
          rst_q <= 1'b0; // RQ12
        end
      end
    end
  endgenerate

  assign rst_pulse = rst_q;

endmodule : upd_dma_rst
`default_nettype wire

// >>> core/upd_ctrl.sv
// transceiver register access port, dma reset and dma control registers
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RQ1) software reads: index, direction bit cleared
// (RQ2) busy stays high until read completes
// (RQ3) read byte lands in bits 15-8
// (RQ4) completion clears busy, sets done flag
// (RQ5) software writes: index, byte, direction set
// (RQ6) busy stays high until write completes
// (RQ7) access starts only while ulpi bus idle
// (RQ8) writes while busy are ignored
// (RQ9) no access without master ready set
// (RQ10) direction bit 6, index bits 5-0
// (RQ11) key 0xa to reset register resets dma
// (RQ12) dma reset exists only with dma option
// (RQ13) control bit 31 selects dma direction
// (RQ14) control bit 30 selects ready source
// (RQ15) ready bits set only after good dma
// (RQ16) ready bits 15..9 and 7..1 mapped
// (RQ17) unready buffer answers tokens with nak
// (RQ18) software writes length register last
// (RQ19) reserved bits read zero, ignore writes
// (RQ20) busy set by the starting write itself
module upd_ctrl #(
  parameter bit DMA_OPTION_PARAM = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ulpi pins
  input wire upd_pkg::upd_ulpi_in_t ulpi_in,
  output var upd_pkg::upd_ulpi_out_t ulpi_out,
  // dma engine
  input wire logic dma_done,
  input wire logic dma_ok,
  output var upd_pkg::upd_dma_ctl_t dma_ctl,
  output logic dma_soft_rst,
  output logic [15:0] buf_rdy_set,
  // token handshake
  input wire logic tok_valid,
  input wire logic [2:0] tok_ep,
  input wire logic tok_buf,
  input wire logic [15:0] buf_ready,
  output logic tok_nak,
  output logic tok_ack
);
  import upd_pkg::*;

  upd_ulpi_in_t pin_s;
  upd_ulpi_out_t uo_q;
  upd_ust_t st_q;
  upd_acc_t acc_q;
  upd_dma_ctl_t dctl_q;
  logic clk_prev_q;
  logic clk_fall;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic acc_ph;
  logic wr_commit;
  logic hit_acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_dsr;
  logic hit_dcr;
  logic mapped;
  logic busy_q;
  logic mrdy_q;
  logic done_q;
  logic acc_end_q;
  logic [7:0] rd_byte_q;
  logic [15:0] rdy_set_q;
  logic nak_q;
  logic ack_q;
  logic [3:0] tok_idx;

  // pin synchronisers
  upd_sync3 #(
    .W($bits(upd_ulpi_in_t))
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(ulpi_in),
    .q(pin_s)
  );

  // keyed dma reset
  upd_dma_rst #(
    .OPT(DMA_OPTION_PARAM)
  ) u_dma_rst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .key_wr(wr_commit && hit_dsr),
    .wdata(pwdata),
    .rst_pulse(dma_soft_rst)
  );

  // address decode and commit strobe
  assign hit_acc = (paddr == UPD_ACC_OFS);
  assign hit_ctrl = (paddr == UPD_CTRL_OFS);
  assign hit_stat = (paddr == UPD_STAT_OFS);
  assign hit_dsr = (paddr == UPD_DSR_OFS);
  assign hit_dcr = (paddr == UPD_DCR_OFS);
  assign mapped = hit_acc | hit_ctrl | hit_stat | hit_dsr | hit_dcr;
  assign acc_ph = psel & penable;
  assign wr_commit = acc_ph & pready_q & pwrite;

  // read data, reserved bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_acc) begin
      rd_mux[UPD_BUSY_BIT] = busy_q;
      rd_mux[UPD_BYTE_LSB +: 8] = acc_q.xcvr_rw_byte; // RQ3 RQ19
      rd_mux[UPD_WR_BIT:0] = {acc_q.xfer_dir_wr, acc_q.xcvr_reg_index};
    end else if (hit_ctrl) begin
      rd_mux[UPD_MRDY_BIT] = mrdy_q;
    end else if (hit_stat) begin
      rd_mux[UPD_DONE_BIT] = done_q;
    end else if (hit_dcr) begin
      rd_mux[UPD_DIR_BIT] = dctl_q.dir;
      rd_mux[UPD_SEL_BIT] = dctl_q.sel;
      rd_mux[15:9] = dctl_q.rdy1; // RQ16
      rd_mux[7:1] = dctl_q.rdy0;
    end
  end

  // apb answer, one wait cycle in the access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (acc_ph && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // master ready control bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mrdy_q <= 1'b0;
    end else if (wr_commit && hit_ctrl) begin
      mrdy_q <= pwdata[UPD_MRDY_BIT];
    end
  end

  // access register fields and busy flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= UPD_ACC_RST; // RQ10
      busy_q <= 1'b0;
    end else if (wr_commit && hit_acc && !busy_q) begin // RQ8
      acc_q <= {pwdata[UPD_BYTE_LSB +: 8], pwdata[UPD_WR_BIT:0]}; // RQ10
      busy_q <= mrdy_q; // RQ20 RQ9
    end else if (acc_end_q) begin
      busy_q <= 1'b0; // RQ4
      if (!acc_q.xfer_dir_wr) begin
        acc_q.xcvr_rw_byte <= rd_byte_q; // RQ3
      end
    end
  end

  // completion flag, write one to clear, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (acc_end_q) begin
      done_q <= 1'b1; // RQ4
    end else if (wr_commit && hit_stat && pwdata[UPD_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // ulpi clock falling edge, pins are stable mid cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= pin_s.clk;
    end
  end
  assign clk_fall = clk_prev_q & ~pin_s.clk;

  // ulpi register access sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= UPD_ST_IDLE;
      uo_q <= '{stp: 1'b0, dout: 8'h00, doe_n: 1'b1};
      acc_end_q <= 1'b0;
      rd_byte_q <= 8'h00;
    end else begin
      acc_end_q <= 1'b0;
      if (clk_fall) begin
        unique case (st_q)
          UPD_ST_IDLE: begin
            if (busy_q && !pin_s.dir) begin // RQ7
              uo_q.dout <= {acc_q.xfer_dir_wr ? UPD_TXCMD_WR : UPD_TXCMD_RD,
                            acc_q.xcvr_reg_index};
              uo_q.doe_n <= 1'b0;
              st_q <= UPD_ST_CMD;
            end
          end
          UPD_ST_CMD: begin
            if (pin_s.dir) begin
              uo_q.dout <= 8'h00; // RQ7
              uo_q.doe_n <= 1'b1;
              st_q <= UPD_ST_IDLE;
            end else if (pin_s.nxt && acc_q.xfer_dir_wr) begin
              uo_q.dout <= acc_q.xcvr_rw_byte;
              st_q <= UPD_ST_WDAT;
            end else if (pin_s.nxt) begin
              uo_q.dout <= 8'h00;
              uo_q.doe_n <= 1'b1;
              st_q <= UPD_ST_RTA;
            end
          end
          UPD_ST_WDAT: begin
            if (pin_s.nxt) begin
              uo_q.stp <= 1'b1;
              uo_q.dout <= 8'h00;
              st_q <= UPD_ST_STP;
            end
          end
          UPD_ST_STP: begin
            uo_q.stp <= 1'b0;
            uo_q.doe_n <= 1'b1;
            acc_end_q <= 1'b1; // RQ6
            st_q <= UPD_ST_IDLE;
          end
          UPD_ST_RTA: begin
            if (pin_s.dir) begin
              st_q <= UPD_ST_RDAT;
            end
          end
          UPD_ST_RDAT: begin
            rd_byte_q <= pin_s.data;
            acc_end_q <= 1'b1; // RQ2
            st_q <= UPD_ST_IDLE;
          end
        endcase
      end
    end
  end

  // dma control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dctl_q <= UPD_DCR_RST; // RQ13 RQ16
    end else if (wr_commit && hit_dcr) begin
      dctl_q <= {pwdata[UPD_DIR_BIT], pwdata[UPD_SEL_BIT], // RQ13 RQ14
                 pwdata[15:9], pwdata[7:1]}; // RQ19
    end
  end

  // hardware buffer ready update after a good transfer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_set_q <= 16'h0000;
    end else if (dma_done && dma_ok && dctl_q.sel) begin // RQ15 RQ14
      rdy_set_q <= {dctl_q.rdy1, 1'b0, dctl_q.rdy0, 1'b0};
    end else begin
      rdy_set_q <= 16'h0000;
    end
  end

  // token answer from buffer ready state
  assign tok_idx = {tok_buf, tok_ep};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nak_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      nak_q <= tok_valid && !buf_ready[tok_idx]; // RQ17
      ack_q <= tok_valid && buf_ready[tok_idx];
    end
  end

  // outputs from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ulpi_out = uo_q;
  assign dma_ctl = dctl_q;
  assign buf_rdy_set = rdy_set_q;
  assign tok_nak = nak_q;
  assign tok_ack = ack_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_busy_hold;
    busy_q && !acc_end_q |=> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) // RQ2 RQ6
    else $error("busy dropped before completion");
  property p_rd_byte;
    acc_end_q && !acc_q.xfer_dir_wr |=>
      acc_q.xcvr_rw_byte == $past(rd_byte_q);
  endproperty
  a_rd_byte: assert property (p_rd_byte) // RQ3
    else $error("read byte not placed in data field");
  property p_done;
    acc_end_q |=> !busy_q && done_q;
  endproperty
  a_done: assert property (p_done) // RQ4
    else $error("completion did not clear busy and set done");
  property p_idle;
    st_q == UPD_ST_IDLE && pin_s.dir |=> st_q == UPD_ST_IDLE;
  endproperty
  a_idle: assert property (p_idle) // RQ7
    else $error("access started while bus not idle");
  property p_ignore;
    wr_commit && hit_acc && busy_q && !acc_end_q |=>
      $stable(acc_q) && busy_q;
  endproperty
  a_ignore: assert property (p_ignore) // RQ8
    else $error("write while busy changed the access register");
  property p_mrdy;
    !mrdy_q && !busy_q |=> !busy_q;
  endproperty
  a_mrdy: assert property (p_mrdy) // RQ9
    else $error("access started without master ready");
  property p_key;
    wr_commit && hit_dsr |=> dma_soft_rst ==
      (DMA_OPTION_PARAM && $past(pwdata) == UPD_DMA_KEY);
  endproperty
  a_key: assert property (p_key) // RQ11 RQ12
    else $error("dma reset does not follow the key");
  property p_rdyset;
    dma_done && !(dma_ok && dctl_q.sel) |=> buf_rdy_set == 16'h0000;
  endproperty
  a_rdyset: assert property (p_rdyset) // RQ15
    else $error("buffer ready set without good dma");
  property p_nak;
    tok_valid && !buf_ready[tok_idx] |=> tok_nak && !tok_ack;
  endproperty
  a_nak: assert property (p_nak) // RQ17
    else $error("unready buffer not answered with nak");
  property p_resv;
    pready_q && !pwrite && hit_dcr |-> (prdata_q & ~UPD_DCR_MASK) == 0;
  endproperty
  a_resv: assert property (p_resv) // RQ19
    else $error("reserved control bits read nonzero");
  property p_set;
    wr_commit && hit_acc && !busy_q && mrdy_q |=> busy_q ##1 busy_q;
  endproperty
  a_set: assert property (p_set) // RQ20
    else $error("starting write did not set busy");

endmodule : upd_ctrl
`default_nettype wire

// >>> test/upd_phy_model.sv
// behavioural ulpi transceiver with a small register file
`timescale 1ns/1ps
`default_nettype none
module upd_phy_model (
  // link side pins
  input wire upd_pkg::upd_ulpi_out_t ulpi_out,
  output var upd_pkg::upd_ulpi_in_t ulpi_in,
  // bench control, holds the bus with receive traffic
  input wire logic hold_dir
);
  import upd_pkg::*;
  logic clk = 1'b0, dir = 1'b0, nxt = 1'b0;
  logic [7:0] dat = 8'h00, last = 8'h00;
  logic [7:0] regs [64];
  logic [5:0] idx = 6'h00;
  int st = 0;
  // free running clock, phase unrelated to the core clock
  initial begin
    #37;
    forever #200 clk = ~clk;
  end
  // released data line toggles so a stale byte never matches
  assign ulpi_in = '{clk: clk, dir: dir, nxt: nxt, data: dir ? dat :
    (ulpi_out.doe_n ? (8'h5a ^ {8{clk}}) : ulpi_out.dout)};
  // sample link pins on the falling edge, clear of their updates
  always @(negedge clk) begin
    if (st == 0 && !dir && !ulpi_out.doe_n && ulpi_out.dout[7]) begin
      idx = ulpi_out.dout[5:0];
      st = ulpi_out.dout[6] ? 3 : 1;
    end else if (st == 1 && ulpi_out.stp) begin
      regs[idx] = last;
      st = 0;
    end else if (st == 1 && !ulpi_out.doe_n) begin
      last = ulpi_out.dout;
    end else if (st == 3 && ulpi_out.doe_n) begin
      st = 4;
    end
  end
  // drive phy pins on the rising edge: accept, turnaround, data
  always @(posedge clk) begin
    nxt <= (st == 1 || st == 3);
    if (st == 4) begin
      dir <= 1'b1;
      st = 5;
    end else if (st == 5) begin
      dat <= regs[idx];
      st = 6;
    end else if (st == 6) begin
      dir <= 1'b0;
      st = 0;
    end else begin
      dir <= hold_dir && st == 0;
    end
  end
endmodule : upd_phy_model
`default_nettype wire

// >>> test/tb_upd_ctrl.sv
// self-checking bench of the phy access and dma control block
`timescale 1ns/1ps
`default_nettype none
module tb_upd_ctrl;
  import upd_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, dma_done = 1'b0, dma_ok = 1'b0;
  logic dma_soft_rst, tok_valid = 1'b0, tok_buf = 1'b0, tok_nak, tok_ack;
  logic hold_dir = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic [2:0] tok_ep = 3'h0;
  logic [15:0] buf_ready = 16'h0000, buf_rdy_set;
  upd_ulpi_in_t ulpi_in;
  upd_ulpi_out_t ulpi_out;
  upd_dma_ctl_t dma_ctl;
  int n_errors = 0, check_count = 0, seed = 32'h0090, k, cnt;

  upd_ctrl #(.DMA_OPTION_PARAM(1'b1)) u_upd_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ulpi_in(ulpi_in),
    .ulpi_out(ulpi_out), .dma_done(dma_done), .dma_ok(dma_ok),
    .dma_ctl(dma_ctl), .dma_soft_rst(dma_soft_rst),
    .buf_rdy_set(buf_rdy_set), .tok_valid(tok_valid), .tok_ep(tok_ep),
    .tok_buf(tok_buf), .buf_ready(buf_ready), .tok_nak(tok_nak),
    .tok_ack(tok_ack));
  upd_phy_model u_upd_phy_model (
    .ulpi_out(ulpi_out), .ulpi_in(ulpi_in), .hold_dir(hold_dir));

  // 20 mhz core clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // expected ready pulse after a dma completes
  function automatic logic [15:0] exp_rdy(input logic [31:0] c, ok);
    return (c[30] && ok) ? (c[15:0] & 16'hfefe) : 16'h0000;
  endfunction : exp_rdy

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h0, 32'h1);
  endtask : apb

  // poll the access register until busy drops, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, UPD_ACC_OFS, 32'h0);
      n++;
    end while (rd[31] !== 1'b0 && n < 300);
    chk("busy_end", {31'h0, rd[31]}, 32'h0);
  endtask : wait_idle

  // one transceiver access: start, poke while busy, wait, check flags
  task automatic xfer(input logic [31:0] w, x, input logic hold);
    apb(1'b1, UPD_ACC_OFS, w);
    apb(1'b0, UPD_ACC_OFS, 32'h0);
    chk("acc_busy", rd, w | 32'h8000_0000);
    apb(1'b1, UPD_ACC_OFS, ~w);
    if (hold) begin
      cnt = 0;
      repeat (60) begin
        @(posedge core_clk);
        cnt += (ulpi_out.doe_n !== 1'b1);
      end
      chk("held_bus", cnt, 32'h0);
      hold_dir <= 1'b0;
    end
    wait_idle();
    chk("acc_end", rd, x);
    apb(1'b0, UPD_STAT_OFS, 32'h0);
    chk("done_set", rd, 32'h1);
    apb(1'b1, UPD_STAT_OFS, 32'h1);
    apb(1'b0, UPD_STAT_OFS, 32'h0);
    chk("done_clr", rd, 32'h0);
  endtask : xfer

  // watchdog, far beyond the expected run
  initial begin
    #(50 * 40000);
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, write-only and unmapped places
    apb(1'b0, UPD_ACC_OFS, 32'h0);
    chk("acc_rst", rd, 32'h0);
    apb(1'b0, UPD_DCR_OFS, 32'h0);
    chk("dcr_rst", rd, 32'h0);
    chk("ctl_rst", {16'h0, dma_ctl}, 32'h0);
    apb(1'b0, UPD_DSR_OFS, 32'h0);
    chk("dsr_rd", rd, 32'h0);
    apb(1'b0, 12'h300, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    // fields kept but no access while master ready is clear
    v = $random(seed);
    apb(1'b1, UPD_ACC_OFS, v);
    repeat (200) @(posedge core_clk);
    apb(1'b0, UPD_ACC_OFS, 32'h0);
    chk("no_mrdy", rd, v & 32'h0000_ff7f);
    apb(1'b1, UPD_CTRL_OFS, 32'h1);
    // random register writes then read-backs, first one held off
    for (k = 0; k < 3; k++) begin
      v = ($random(seed) & 32'h0000_ff3f) | 32'h40;
      hold_dir <= (k == 0);
      repeat (40) @(posedge core_clk);
      xfer(v, v, k == 0);
      xfer(v & 32'h3f, v & 32'hff3f, 1'b0);
    end
    // dma control fields, ready pulse after good or failed dma
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      v[30] = k[0];
      apb(1'b1, UPD_DCR_OFS, v);
      apb(1'b0, UPD_DCR_OFS, 32'h0);
      chk("dcr_rd", rd, v & UPD_DCR_MASK);
      chk("ctl", dma_ctl, {v[31:30], v[15:9], v[7:1]});
      dma_done <= 1'b1;
      dma_ok <= k[1];
      @(posedge core_clk);
      dma_done <= 1'b0;
      @(posedge core_clk);
      chk("rdy_set", buf_rdy_set, exp_rdy(v, k[1]));
    end
    // stray value does nothing, the key pulses once
    for (k = 0; k < 2; k++) begin
      v = k ? UPD_DMA_KEY : ($random(seed) | 32'h100);
      apb(1'b1, UPD_DSR_OFS, v);
      cnt = 0;
      repeat (4) begin
        @(posedge core_clk);
        cnt += dma_soft_rst;
      end
      chk("dma_rst", cnt, k);
    end
    // token answers follow buffer ready status
    for (k = 0; k < 16; k++) begin
      v = $random(seed);
      e = v[{v[19] & (|v[18:16]), v[18:16]}];
      buf_ready <= v[15:0];
      tok_ep <= v[18:16];
      tok_buf <= v[19] & (|v[18:16]);
      tok_valid <= 1'b1;
      @(posedge core_clk);
      tok_valid <= 1'b0;
      @(posedge core_clk);
      chk("tok_nak", tok_nak, !e);
      chk("tok_ack", tok_ack, e);
    end
    end_of_test();
  end
endmodule : tb_upd_ctrl
`default_nettype wire
